// ===== logic/bridge_defines.svh
// Purpose: Named offsets, fields, codes and reset values of the bridge.
// Assumes: Included by the bridge module and the testbench.
// Notes:   Definitions only.
`ifndef BRIDGE_DEFINES_SVH
`define BRIDGE_DEFINES_SVH

`define OFS_CMD       8'h04
`define OFS_CLS       8'h0C
`define OFS_WIC       8'h74
`define OFS_DISC      8'h78
`define OFS_STAT      8'h80

`define SERR_EN_BIT   8
`define WIC_HI        8
`define WIC_LO        7
`define MWI_LINE      2'h3
`define MWI_AS_MW     2'h0

`define CMD_IOW       4'h3
`define CMD_MW        4'h7
`define CMD_CFGW      4'hB
`define CMD_MWI       4'hF
`define CFG_TYPE1     2'h1
`define AD_ALIGNED    2'h0

`define WIC_RST       32'h0000_0000
`define DISC_RST      32'h0000_1000
`define CLS_RST       8'h00
`define RETRY_DEF     32'h0100_0000
`define LAT_DEF       8'h20
`define DW_STEP       32'h0000_0004

`define STAT_RETRY    0
`define STAT_DISC     1
`define STAT_TABT     2
`define STAT_DQV      4
`define STAT_DQD      5
`define STAT_PQV      6

`endif

// ===== logic/bridge_pkg.sv
// Purpose: State types of the bridge write path.
// Assumes: One-hot codes, decoded with plain case statements.
// Notes:   Numbers live in bridge_defines.svh.
package bridge_pkg;
  typedef enum logic [6:0] {
    T_IDLE = 7'h01, T_DEC = 7'h02, T_DEVS = 7'h04, T_POST = 7'h08,
    T_DLY  = 7'h10, T_RESP = 7'h20, T_TURN = 7'h40
  } tgt_state_type;
  typedef enum logic [3:0] {
    M_IDLE = 4'h1, M_REQ = 4'h2, M_DATA = 4'h4, M_TURN = 4'h8
  } mst_state_type;
endpackage

// ===== logic/bridge_write_fwd.sv
// Purpose: Write forwarding of a PCI-to-PCI bridge, primary to secondary.
// Assumes: One clock; pins synchronous; p_decode_hit from a positive decoder.
// Notes:   Posted writes pass a DWORD buffer; delayed writes use one entry.
`timescale 1ns/1ps
`include "bridge_defines.svh"

module bridge_write_fwd #(
  parameter int          DEPTH       = 32,
  parameter logic [31:0] RETRY_LIMIT = `RETRY_DEF,
  parameter logic [7:0]  LAT_CYCLES  = `LAT_DEF
) (
  input  logic        sys_clk,
  input  logic        rstn,
  input  logic [7:0]  reg_addr,
  input  logic [31:0] reg_wdata,
  input  logic        reg_wr,
  input  logic        reg_rd,
  output logic [31:0] reg_rdata,
  input  logic        p_frame_n,
  input  logic        p_irdy_n,
  input  logic [31:0] p_ad,
  input  logic [3:0]  p_cbe_n,
  input  logic        p_decode_hit,
  input  logic        p_vga_hit,
  output logic        p_devsel_n,
  output logic        p_trdy_n,
  output logic        p_stop_n,
  output logic        p_tgt_oe,
  output logic        p_serr_n_out,
  output logic        p_serr_n_oe,
  input  logic        s_gnt_n,
  input  logic        s_frame_in_n,
  input  logic        s_irdy_in_n,
  input  logic        s_trdy_n,
  input  logic        s_stop_n,
  input  logic        s_devsel_n,
  output logic        s_req_n,
  output logic        s_frame_n,
  output logic        s_irdy_n,
  output logic [31:0] s_ad,
  output logic [3:0]  s_cbe_n,
  output logic        s_drive_oe
);
  import bridge_pkg::*;
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int AW = $clog2(DEPTH);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic        serr_en_r, serr_en_nxt;
  logic [7:0]  cls_r, cls_nxt;
  logic [31:0] wic_r, wic_nxt, disc_r, disc_nxt, rdata_r, rdata_nxt;
  logic [2:0]  stat_r, stat_nxt, stat_set;
  logic [1:0]  mwi_mode;
  logic        dq_valid_r, dq_done_r, pq_valid_r;

  assign mwi_mode = wic_r[`WIC_HI:`WIC_LO];

  always_comb begin
    serr_en_nxt = serr_en_r;
    cls_nxt     = cls_r;
    wic_nxt     = wic_r;
    disc_nxt    = disc_r;
    rdata_nxt   = 32'h0000_0000;
    stat_nxt    = stat_r | stat_set;
    if (reg_wr) begin
      case (reg_addr)
        `OFS_CMD:  serr_en_nxt = reg_wdata[`SERR_EN_BIT];
        `OFS_CLS:  cls_nxt = reg_wdata[7:0];
        `OFS_WIC:  wic_nxt = reg_wdata;
        `OFS_DISC: disc_nxt = reg_wdata;
        `OFS_STAT: stat_nxt = (stat_r & ~reg_wdata[2:0]) | stat_set;
        default:   ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `OFS_CMD:  rdata_nxt[`SERR_EN_BIT] = serr_en_r;
        `OFS_CLS:  rdata_nxt[7:0] = cls_r;
        `OFS_WIC:  rdata_nxt = wic_r;
        `OFS_DISC: rdata_nxt = disc_r;
        `OFS_STAT: begin
          rdata_nxt[2:0]       = stat_r;
          rdata_nxt[`STAT_DQV] = dq_valid_r;
          rdata_nxt[`STAT_DQD] = dq_done_r;
          rdata_nxt[`STAT_PQV] = pq_valid_r;
        end
        default:   rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      serr_en_r <= 1'b0;
      cls_r     <= `CLS_RST;
      wic_r     <= `WIC_RST;
      disc_r    <= `DISC_RST;
      rdata_r   <= 32'h0000_0000;
      stat_r    <= 3'h0;
    end else begin
      serr_en_r <= serr_en_nxt;
      cls_r     <= cls_nxt;
      wic_r     <= wic_nxt;
      disc_r    <= disc_nxt;
      rdata_r   <= rdata_nxt;
      stat_r    <= stat_nxt;
    end
  end
  assign reg_rdata = rdata_r;

  // ------------------------------------------------------------
  // Target side on the primary bus
  // ------------------------------------------------------------
  tgt_state_type t_st_r, t_st_nxt;
  logic [31:0] t_addr_r, t_addr_nxt, dq_addr_r, dq_data_r;
  logic [3:0]  t_cmd_r, t_cmd_nxt, dq_cmd_r, dq_be_r;
  logic        t_vga_r, t_vga_nxt, pframe_r;
  logic        devsel_r, devsel_nxt, trdy_r, trdy_nxt, stop_r, stop_nxt;
  logic        toe_r, toe_nxt;
  logic        t_push, t_open, t_close, dq_enq, dq_take;
  logic        is_post, is_dly, room, misal, dq_match;
  logic [CW-1:0] pcount_r;
  logic [3:0]  byte_ok;

  // Invalidate writes stop at cache lines only for power-of-two sizes from 1 to 16 DWORDs.
  function automatic logic last_dw(input logic [31:0] a);
    logic line_ok;
    line_ok = (cls_r == 8'h01) || (cls_r == 8'h02) || (cls_r == 8'h04) ||
              (cls_r == 8'h08) || (cls_r == 8'h10);
    if (t_cmd_r == `CMD_MWI && mwi_mode == `MWI_LINE && line_ok)
      last_dw = ((a[9:2] & (cls_r - 8'h01)) == (cls_r - 8'h01));
    else
      last_dw = &a[11:2];
  endfunction

  assign is_post = (t_cmd_r == `CMD_MW && !t_vga_r) ||
                   t_cmd_r == `CMD_MWI;
  assign is_dly  = t_cmd_r == `CMD_IOW || (t_cmd_r == `CMD_MW && t_vga_r) ||
                   (t_cmd_r == `CMD_CFGW &&
                    t_addr_r[1:0] == `CFG_TYPE1);
  assign room    = !pq_valid_r && pcount_r < CW'(DEPTH);
  assign misal   = t_addr_r[1:0] != `AD_ALIGNED;

  for (genvar i = 0; i < 4; i++) begin : g_cmp
    assign byte_ok[i] = p_cbe_n[i] ||
                        p_ad[8*i +: 8] == dq_data_r[8*i +: 8];
  end
  assign dq_match = dq_valid_r && t_addr_r == dq_addr_r &&
                    t_cmd_r == dq_cmd_r && p_cbe_n == dq_be_r && &byte_ok;

  always_comb begin
    t_st_nxt   = t_st_r;
    t_addr_nxt = t_addr_r;
    t_cmd_nxt  = t_cmd_r;
    t_vga_nxt  = t_vga_r;
    devsel_nxt = devsel_r;
    trdy_nxt   = trdy_r;
    stop_nxt   = stop_r;
    toe_nxt    = toe_r;
    t_push = 1'b0;
    t_open = 1'b0;
    t_close = 1'b0;
    dq_enq = 1'b0;
    dq_take = 1'b0;
    case (t_st_r)
      T_IDLE: if (!p_frame_n && pframe_r && p_decode_hit) begin
        t_addr_nxt = p_ad;
        t_cmd_nxt  = p_cbe_n;
        t_vga_nxt  = p_vga_hit;
        t_st_nxt   = T_DEC;
      end
      T_DEC: begin
        t_st_nxt = T_IDLE;
        if (is_post || is_dly) begin
          devsel_nxt = 1'b0;
          toe_nxt    = 1'b1;
          t_st_nxt   = is_post ? T_DEVS : T_DLY;
        end
      end
      T_DEVS: if (room) begin
        trdy_nxt = 1'b0;
        stop_nxt = !(misal || last_dw(t_addr_r) ||
                     pcount_r + CW'(1) >= CW'(DEPTH));
        t_open   = 1'b1;
        t_st_nxt = T_POST;
      end else begin
        stop_nxt = 1'b0;
        t_st_nxt = T_RESP;
      end
      T_POST: if (!p_irdy_n) begin
        t_push = 1'b1;
        if (p_frame_n || !stop_r) begin
          {devsel_nxt, trdy_nxt, stop_nxt} = 3'h7;
          t_close  = 1'b1;
          t_st_nxt = T_TURN;
        end else begin
          t_addr_nxt = t_addr_r + `DW_STEP;
          stop_nxt   = !(last_dw(t_addr_nxt) ||
                         pcount_r + CW'(2) >= CW'(DEPTH));
        end
      end
      T_DLY: if (!p_irdy_n) begin
        if (dq_match && dq_done_r) begin
          trdy_nxt = 1'b0;
          stop_nxt = p_frame_n;
          dq_take  = 1'b1;
        end else begin
          stop_nxt = 1'b0;
          dq_enq   = !dq_valid_r;
        end
        t_st_nxt = T_RESP;
      end
      T_RESP: if (!p_irdy_n) begin
        {devsel_nxt, trdy_nxt, stop_nxt} = 3'h7;
        t_st_nxt = T_TURN;
      end
      T_TURN: begin
        toe_nxt  = 1'b0;
        t_st_nxt = T_IDLE;
      end
      default: t_st_nxt = T_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      t_st_r   <= T_IDLE;
      t_addr_r <= 32'h0000_0000;
      t_cmd_r  <= 4'h0;
      t_vga_r  <= 1'b0;
      pframe_r <= 1'b1;
      {devsel_r, trdy_r, stop_r} <= 3'h7;
      toe_r    <= 1'b0;
    end else begin
      t_st_r   <= t_st_nxt;
      t_addr_r <= t_addr_nxt;
      t_cmd_r  <= t_cmd_nxt;
      t_vga_r  <= t_vga_nxt;
      pframe_r <= p_frame_n;
      {devsel_r, trdy_r, stop_r} <= {devsel_nxt, trdy_nxt, stop_nxt};
      toe_r    <= toe_nxt;
    end
  end
  assign p_devsel_n = devsel_r;
  assign p_trdy_n   = trdy_r;
  assign p_stop_n   = stop_r;
  assign p_tgt_oe   = toe_r;

  // ------------------------------------------------------------
  // Master side on the secondary bus
  // ------------------------------------------------------------
  mst_state_type m_st_r, m_st_nxt;
  logic        m_dly_r, m_dly_nxt, req_r, req_nxt, mfr_r, mfr_nxt;
  logic        mirdy_r, mirdy_nxt, moe_r, moe_nxt;
  logic [31:0] mad_r, mad_nxt, pq_addr_r;
  logic [3:0]  mcbe_r, mcbe_nxt, pq_cmd_r;
  logic [7:0]  lat_r, lat_nxt;
  logic        m_pop, m_tabt, m_dly_ok, m_dly_retry, has_post;
  logic [35:0] mem [DEPTH];
  logic [AW-1:0] rd_r, wr_r;
  logic [CW-1:0] rem;

  assign has_post = pq_valid_r && pcount_r != CW'(0);
  // Words left after this phase; matches m_pop in the trdy branch without
  // reading m_pop back into the process that drives it.
  assign rem = pcount_r - CW'(!m_dly_r);

  always_comb begin
    m_st_nxt = m_st_r;
    m_dly_nxt = m_dly_r;
    req_nxt = req_r;
    mfr_nxt = mfr_r;
    mirdy_nxt = mirdy_r;
    moe_nxt = moe_r;
    mad_nxt = mad_r;
    mcbe_nxt = mcbe_r;
    lat_nxt = (lat_r != 8'h00) ? lat_r - 8'h01 : lat_r;
    m_pop = 1'b0;
    m_tabt = 1'b0;
    m_dly_ok = 1'b0;
    m_dly_retry = 1'b0;
    case (m_st_r)
      M_IDLE: if (has_post || (dq_valid_r && !dq_done_r)) begin
        req_nxt   = 1'b0;
        m_dly_nxt = !has_post;
        m_st_nxt  = M_REQ;
      end
      M_REQ: if (!s_gnt_n && s_frame_in_n && s_irdy_in_n) begin
        mfr_nxt  = 1'b0;
        moe_nxt  = 1'b1;
        req_nxt  = 1'b1;
        lat_nxt  = LAT_CYCLES;
        mad_nxt  = m_dly_r ? dq_addr_r : pq_addr_r;
        mcbe_nxt = m_dly_r ? dq_cmd_r :
                   (pq_cmd_r == `CMD_MWI && mwi_mode == `MWI_AS_MW) ?
                   `CMD_MW : pq_cmd_r;
        m_st_nxt = M_DATA;
      end
      M_DATA: if (mirdy_r) begin
        mirdy_nxt = 1'b0;
        mad_nxt   = m_dly_r ? dq_data_r : mem[rd_r][31:0];
        mcbe_nxt  = m_dly_r ? dq_be_r : mem[rd_r][35:32];
        mfr_nxt   = m_dly_r || pcount_r <= CW'(1);
      end else if (!s_stop_n && s_devsel_n) begin
        m_tabt = 1'b1;
        {mfr_nxt, mirdy_nxt} = 2'h3;
        m_st_nxt = M_TURN;
      end else if (!s_trdy_n) begin
        m_pop    = !m_dly_r;
        m_dly_ok = m_dly_r;
        if (mfr_r || !s_stop_n || rem == CW'(0)) begin
          {mfr_nxt, mirdy_nxt} = 2'h3;
          m_st_nxt = M_TURN;
        end else begin
          mad_nxt  = mem[rd_r + AW'(1)][31:0];
          mcbe_nxt = mem[rd_r + AW'(1)][35:32];
          mfr_nxt  = rem <= CW'(1) ||
                     (lat_r == 8'h00 && s_gnt_n);
        end
      end else if (!s_stop_n) begin
        m_dly_retry = m_dly_r;
        {mfr_nxt, mirdy_nxt} = 2'h3;
        m_st_nxt = M_TURN;
      end
      M_TURN: begin
        moe_nxt  = 1'b0;
        m_st_nxt = M_IDLE;
      end
      default: m_st_nxt = M_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      m_st_r <= M_IDLE;
      m_dly_r <= 1'b0;
      {req_r, mfr_r, mirdy_r, moe_r} <= 4'hE;
      mad_r  <= 32'h0000_0000;
      mcbe_r <= 4'h0;
      lat_r  <= 8'h00;
    end else begin
      m_st_r <= m_st_nxt;
      m_dly_r <= m_dly_nxt;
      {req_r, mfr_r, mirdy_r, moe_r} <= {req_nxt, mfr_nxt, mirdy_nxt, moe_nxt};
      mad_r  <= mad_nxt;
      mcbe_r <= mcbe_nxt;
      lat_r  <= lat_nxt;
    end
  end
  assign s_req_n    = req_r;
  assign s_frame_n  = mfr_r;
  assign s_irdy_n   = mirdy_r;
  assign s_ad       = mad_r;
  assign s_cbe_n    = mcbe_r;
  assign s_drive_oe = moe_r;

  // ------------------------------------------------------------
  // Posted buffer, delayed entry and discard timer
  // ------------------------------------------------------------
  logic [AW-1:0] rd_nxt, wr_nxt;
  logic [CW-1:0] pcount_nxt;
  logic        pq_valid_nxt, pq_open_r, pq_open_nxt, serr_r, serr_nxt;
  logic        dq_valid_nxt, dq_done_nxt;
  logic [31:0] pq_addr_nxt, dq_addr_nxt, dq_data_nxt, tries_r, tries_nxt;
  logic [31:0] dtmr_r, dtmr_nxt;
  logic [3:0]  pq_cmd_nxt, dq_cmd_nxt, dq_be_nxt;
  logic        lim_hit, disc_hit;

  always_comb begin
    rd_nxt = rd_r + AW'(m_pop);
    wr_nxt = wr_r + AW'(t_push);
    pcount_nxt = pcount_r + CW'(t_push) - CW'(m_pop);
    pq_addr_nxt = m_pop ? pq_addr_r + `DW_STEP : pq_addr_r;
    pq_cmd_nxt = pq_cmd_r;
    pq_open_nxt = pq_open_r && !t_close;
    pq_valid_nxt = pq_valid_r;
    if (t_open) begin
      {pq_valid_nxt, pq_open_nxt} = 2'h3;
      pq_addr_nxt = t_addr_r;
      pq_cmd_nxt  = t_cmd_r;
    end
    if (m_tabt && !m_dly_r) begin
      rd_nxt = wr_nxt;
      pcount_nxt = CW'(t_push);
    end
    if (pq_valid_r && !pq_open_nxt && pcount_nxt == CW'(0))
      pq_valid_nxt = 1'b0;
    dq_valid_nxt = dq_valid_r;
    dq_done_nxt = dq_done_r;
    dq_addr_nxt = dq_addr_r;
    dq_cmd_nxt = dq_cmd_r;
    dq_data_nxt = dq_data_r;
    dq_be_nxt = dq_be_r;
    tries_nxt = tries_r;
    dtmr_nxt = (dtmr_r != 32'h0000_0000) ? dtmr_r - 32'h0000_0001 : dtmr_r;
    lim_hit = m_dly_retry && tries_r + 32'h0000_0001 >= RETRY_LIMIT;
    disc_hit = dq_done_r && !dq_take && dtmr_r == 32'h0000_0000;
    if (dq_enq) begin
      {dq_valid_nxt, dq_done_nxt} = 2'h2;
      dq_addr_nxt = t_addr_r;
      dq_cmd_nxt  = t_cmd_r;
      dq_data_nxt = p_ad;
      dq_be_nxt   = p_cbe_n;
      tries_nxt   = 32'h0000_0000;
    end
    if (m_dly_retry)
      tries_nxt = tries_r + 32'h0000_0001;
    if (m_dly_ok) begin
      dq_done_nxt = 1'b1;
      dtmr_nxt = disc_r;
    end
    if (dq_take || disc_hit || lim_hit || (m_tabt && m_dly_r))
      {dq_valid_nxt, dq_done_nxt} = 2'h0;
    stat_set = {m_tabt, disc_hit, lim_hit};
    serr_nxt = serr_en_r && (lim_hit || disc_hit);
  end

  always_ff @(posedge sys_clk) begin
    if (t_push)
      mem[wr_r] <= {p_cbe_n, p_ad};
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      {rd_r, wr_r} <= '0;
      pcount_r <= '0;
      {pq_valid_r, pq_open_r, dq_valid_r, dq_done_r, serr_r} <= 5'h00;
      {pq_addr_r, dq_addr_r, dq_data_r} <= '0;
      {pq_cmd_r, dq_cmd_r, dq_be_r} <= 12'h000;
      tries_r <= 32'h0000_0000;
      dtmr_r  <= 32'h0000_0000;
    end else begin
      {rd_r, wr_r} <= {rd_nxt, wr_nxt};
      pcount_r <= pcount_nxt;
      {pq_valid_r, pq_open_r, dq_valid_r, dq_done_r, serr_r} <=
        {pq_valid_nxt, pq_open_nxt, dq_valid_nxt, dq_done_nxt, serr_nxt};
      {pq_addr_r, dq_addr_r, dq_data_r} <= {pq_addr_nxt, dq_addr_nxt,
                                            dq_data_nxt};
      {pq_cmd_r, dq_cmd_r, dq_be_r} <= {pq_cmd_nxt, dq_cmd_nxt, dq_be_nxt};
      tries_r <= tries_nxt;
      dtmr_r  <= dtmr_nxt;
    end
  end
  // The error line is open-drain: it only ever pulls low.
  assign p_serr_n_out = 1'b0 & serr_r;
  assign p_serr_n_oe  = serr_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_trdy_follows_devsel: assert property (@(posedge sys_clk)
    disable iff (!rstn) (t_st_r == T_DEVS && room) |=> !trdy_r && !devsel_r)
    else $error("trdy not one cycle after devsel");
  a_no_tgt_wait: assert property (@(posedge sys_clk)
    disable iff (!rstn) (t_st_r == T_POST) |-> !trdy_r)
    else $error("posted target wait state");
  a_misalign_stop: assert property (@(posedge sys_clk)
    disable iff (!rstn) (t_st_r == T_DEVS && room && misal) |=> !stop_r)
    else $error("misaligned burst not disconnected");
  a_delay_first_retry: assert property (@(posedge sys_clk)
    disable iff (!rstn) (t_st_r == T_DLY && !p_irdy_n && !dq_valid_r)
    |=> !stop_r && trdy_r && dq_valid_r)
    else $error("first delayed write not retried");
  a_entry_kept: assert property (@(posedge sys_clk)
    disable iff (!rstn) (dq_valid_r && dq_valid_nxt) |=> $stable(dq_addr_r))
    else $error("delayed entry replaced");
  a_mwi_as_mw: assert property (@(posedge sys_clk)
    disable iff (!rstn) ($fell(mfr_r) && mwi_mode == `MWI_AS_MW)
    |-> mcbe_r != `CMD_MWI)
    else $error("invalidate not converted");
  a_data_after_addr: assert property (@(posedge sys_clk)
    disable iff (!rstn) $fell(mfr_r) |=> !mirdy_r)
    else $error("no data phase after address");
  a_req_on_head: assert property (@(posedge sys_clk)
    disable iff (!rstn) (m_st_r == M_IDLE && has_post) |=> !req_r)
    else $error("bus not requested");
  a_serr_gated: assert property (@(posedge sys_clk)
    disable iff (!rstn)
    serr_r |-> $past(serr_en_r) && $past(stat_set[1:0] != 2'h0))
    else $error("serr without enable or cause");
endmodule

// ===== verification/pci_target_model.sv
// Purpose: Secondary-bus target that takes the forwarded writes.
// Assumes: Answers one cycle after the address phase.
// Notes:   mode 0 accepts, 1 retries every attempt, 2 aborts.
`timescale 1ns/1ps
module pci_target_model (
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic [1:0]  mode,
  input  wire logic        s_frame_n,
  input  wire logic        s_irdy_n,
  input  wire logic [31:0] s_ad,
  input  wire logic [3:0]  s_cbe_n,
  input  wire logic        s_drive_oe,
  output logic             s_devsel_n,
  output logic             s_trdy_n,
  output logic             s_stop_n,
  output logic [7:0]       count,
  output logic [31:0]      last_addr,
  output logic [31:0]      last_data,
  output logic [3:0]       last_cmd
);
  logic busy;
  // ----------------------------------------------------------------
  // Target response
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      busy       <= 1'b0;
      s_devsel_n <= 1'b1;
      s_trdy_n   <= 1'b1;
      s_stop_n   <= 1'b1;
      count      <= 8'h00;
    end else if (!busy) begin
      if (s_drive_oe && !s_frame_n) begin
        busy       <= 1'b1;
        last_addr  <= s_ad;
        last_cmd   <= s_cbe_n;
        s_devsel_n <= (mode == 2'h2);
        s_trdy_n   <= (mode != 2'h0);
        s_stop_n   <= (mode == 2'h0);
      end
    end else if (!s_irdy_n && (!s_trdy_n || !s_stop_n)) begin
      if (!s_trdy_n) begin
        count     <= count + 8'h01;
        last_data <= s_ad;
      end
      // Released lines are pulled up, so idle shows all ones.
      if (s_frame_n || !s_stop_n) begin
        busy       <= 1'b0;
        s_devsel_n <= 1'b1;
        s_trdy_n   <= 1'b1;
        s_stop_n   <= 1'b1;
      end
    end
  end
endmodule

// ===== verification/testbench.sv
// Purpose: Self-checking bench for bridge write forwarding.
// Assumes: DEPTH 4, retry limit 4, latency 4 to keep runs short.
// Notes:   Holding the grant off stalls the secondary so buffers fill.
`timescale 1ns/1ps
`include "bridge_defines.svh"
module testbench;
  logic        sys_clk, rstn, reg_wr, reg_rd, p_frame_n, p_irdy_n;
  logic        p_decode_hit, p_vga_hit, p_devsel_n, p_trdy_n, p_stop_n;
  logic        p_tgt_oe, p_serr_n_out, p_serr_n_oe, s_gnt_n, s_req_n;
  logic        s_frame_n, s_irdy_n, s_trdy_n, s_stop_n, s_devsel_n;
  logic        s_drive_oe, s_frame_in_n, s_irdy_in_n, gnt_hold;
  logic [7:0]  reg_addr, count;
  logic [31:0] reg_wdata, reg_rdata, p_ad, s_ad, last_addr, last_data, d;
  logic [3:0]  p_cbe_n, s_cbe_n, last_cmd;
  logic [1:0]  mode;
  int          fail_count = 0, cmp_count = 0, cyc = 0, got;
  assign s_gnt_n      = gnt_hold | s_req_n;
  assign s_frame_in_n = s_drive_oe ? s_frame_n : 1'b1;
  assign s_irdy_in_n  = s_drive_oe ? s_irdy_n : 1'b1;
  bridge_write_fwd #(.DEPTH(4), .RETRY_LIMIT(32'h4), .LAT_CYCLES(8'h4))
    bridge_write_fwd_i (.*);
  pci_target_model pci_target_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask
  // Primary write of n words; got counts the phases taken with trdy.
  task automatic pw(input logic [31:0] a, input logic [3:0] c, input int n,
                    input logic [1:0] h, input logic [31:0] dd,
                    input logic [3:0] be);
    got = 0;
    @(posedge sys_clk);
    p_frame_n    <= 1'b0;
    p_ad         <= a;
    p_cbe_n      <= c;
    p_decode_hit <= h[0];
    p_vga_hit    <= h[1];
    @(posedge sys_clk);
    {p_decode_hit, p_vga_hit} <= 2'h0;
    p_irdy_n     <= 1'b0;
    p_ad         <= dd;
    p_cbe_n      <= be;
    p_frame_n    <= (n == 1);
    for (int k = 0; k < 16; k++) begin
      @(posedge sys_clk);
      if (p_trdy_n === 1'b0) got++;
      if (p_stop_n === 1'b0 || got == n) break;
      p_ad      <= dd + got;
      p_frame_n <= (got >= n - 1);
    end
    {p_frame_n, p_irdy_n} <= 2'h3;
    p_ad <= ~dd;
    @(posedge sys_clk);
  endtask
  task automatic waitn(input int n);
    for (int k = 0; k < 300 && count != n; k++) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rstn, reg_wr, reg_rd, p_decode_hit, p_vga_hit, gnt_hold} = 6'h00;
    {p_frame_n, p_irdy_n} = 2'h3;
    {reg_addr, reg_wdata, p_ad, p_cbe_n, mode} = 78'h0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    chk("idle pins", {p_tgt_oe, s_drive_oe, p_devsel_n, s_req_n}, 4'h3);
    rd(`OFS_WIC, d); chk("wic reset", d, `WIC_RST);
    rd(`OFS_DISC, d); chk("disc reset", d, `DISC_RST);
    rd(8'h10, d); chk("unmapped", d, 32'h0);
    wr(`OFS_CLS, 32'h4);
    wr(`OFS_CMD, 32'h100);
    $display("registers done");
    pw(32'h1000_0000, `CMD_MW, 4, 2'h1, 32'hD000_0000, 4'h0);
    chk("posted words", got, 4);
    waitn(4);
    chk("fwd addr", last_addr, 32'h1000_0000);
    chk("fwd cmd", last_cmd, `CMD_MW);
    chk("fwd data", last_data, 32'hD000_0003);
    pw(32'h1000_0102, `CMD_MW, 3, 2'h1, 32'hC000_0000, 4'h0);
    chk("misaligned", got, 1);
    waitn(5);
    pw(32'h1000_0200, `CMD_MW, 1, 2'h0, 32'h0, 4'h0);
    chk("no decode", got, 0);
    $display("posted done");
    gnt_hold <= 1'b1;
    pw(32'h1000_0300, `CMD_MW, 8, 2'h1, 32'hB000_0000, 4'h0);
    chk("full stop", got, 4);
    pw(32'h1000_0400, `CMD_MW, 1, 2'h1, 32'h0, 4'h0);
    chk("busy retry", got, 0);
    gnt_hold <= 1'b0;
    waitn(9);
    chk("drained", count, 8'h09);
    chk("drain data", last_data, 32'hB000_0003);
    wr(`OFS_WIC, 32'h180);
    rd(`OFS_WIC, d); chk("wic", d, 32'h180);
    pw(32'h2000_0008, `CMD_MWI, 4, 2'h1, 32'hA000_0000, 4'h0);
    chk("line stop", got, 2);
    waitn(11);
    chk("mwi cmd", last_cmd, `CMD_MWI);
    wr(`OFS_WIC, 32'h0);
    pw(32'h2000_0010, `CMD_MWI, 1, 2'h1, 32'hA000_0010, 4'h0);
    waitn(12);
    chk("mwi as mw", last_cmd, `CMD_MW);
    $display("invalidate done");
    gnt_hold <= 1'b1;
    pw(32'h0000_0300, `CMD_IOW, 1, 2'h1, 32'h1111_11AA, 4'hE);
    chk("first retry", got, 0);
    pw(32'h0000_0300, `CMD_IOW, 1, 2'h1, 32'h1111_11AA, 4'hE);
    chk("early repeat", got, 0);
    gnt_hold <= 1'b0;
    waitn(13);
    repeat (10) @(posedge sys_clk);
    chk("one entry", count, 8'h0D);
    chk("io data", last_data, 32'h1111_11AA);
    pw(32'h0000_0300, `CMD_IOW, 2, 2'h1, 32'h2222_22AA, 4'hE);
    chk("completion", got, 1);
    wr(`OFS_DISC, 32'h14);
    pw(32'h000A_0000, `CMD_MW, 1, 2'h3, 32'h5, 4'h0);
    chk("vga delayed", got, 0);
    waitn(14);
    repeat (60) @(posedge sys_clk);
    rd(`OFS_STAT, d); chk("discard", d & 32'h2, 32'h2);
    wr(`OFS_STAT, 32'h2);
    $display("delayed done");
    mode <= 2'h1;
    pw(32'h0001_0001, `CMD_CFGW, 1, 2'h1, 32'h6, 4'h0);
    chk("cfg retry", got, 0);
    for (int k = 0; k < 400 && got == 0; k++) begin
      @(posedge sys_clk);
      if (p_serr_n_oe === 1'b1) got = 1;
    end
    chk("serr", got, 1);
    rd(`OFS_STAT, d); chk("retry limit", d & 32'h1, 32'h1);
    mode <= 2'h2;
    pw(32'h1000_0500, `CMD_MW, 2, 2'h1, 32'hE000_0000, 4'h0);
    chk("abort accept", got, 2);
    repeat (40) @(posedge sys_clk);
    rd(`OFS_STAT, d); chk("abort flag", d & 32'h4, 32'h4);
    chk("abort drop", count, 8'h0E);
    mode <= 2'h0;
    $display("errors done");
    close_out();
  end
endmodule
